// file: src/aobf_formatter.sv
// Output bus formatter for a dual-channel 10-bit converter.
// Assumes the sampling clock arrives as a pin slower than clk, the core's
// samples are on clk and stable at each sampling-clock rising edge, and the
// mode pins are static straps.
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.

module aobf_formatter import aobf_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_clk_pin,
  input wire logic bus_split_select,
  input wire logic edge_phase_select,
  input wire aobf_sample_s sample_chan_a,
  input wire aobf_sample_s sample_chan_b,
  input wire logic [AOBF_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic fwd_clock_chan_a,
  output logic fwd_clock_chan_b,
  output logic range_flag_chan_a,
  output logic range_flag_chan_b,
  output logic [AOBF_CODE_W-1:0] late_word_chan_a,
  output logic [AOBF_CODE_W-1:0] late_word_chan_b,
  output logic [AOBF_CODE_W-1:0] early_word_chan_a,
  output logic [AOBF_CODE_W-1:0] early_word_chan_b,
  output logic early_oe_n_chan_a,
  output logic early_oe_n_chan_b
);

  function automatic logic [AOBF_CODE_W-1:0] sat_code(input aobf_sample_s s);
    if (s.over_pos) begin
      sat_code = AOBF_CODE_MAX;
    end else if (s.over_neg) begin
      sat_code = AOBF_CODE_MIN;
    end else begin
      sat_code = s.code;
    end
  endfunction

  function automatic logic out_of_range(input aobf_sample_s s);
    out_of_range = s.over_pos | s.over_neg;
  endfunction

  // Pin synchronisers: bit 0 sampling clock, bit 1 mode, bit 2 phase
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sclk_prev_r;

  // Only the second stage is read by logic, so a metastable first stage never fans out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {edge_phase_select, bus_split_select, sample_clk_pin};
      sync2_r <= sync1_r;
    end
  end

  // Previous synchronised sampling clock, for rising-edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sync2_r[0];
    end
  end

  logic strobe;
  logic single_mode;
  logic phase90;
  assign strobe = sync2_r[0] & ~sclk_prev_r;
  assign single_mode = sync2_r[1];
  assign phase90 = sync2_r[2] & ~sync2_r[1];

  aobf_sample_s smp [AOBF_CHANS];
  always_comb begin
    smp[0] = sample_chan_a;
    smp[1] = sample_chan_b;
  end

  // Control and bus slave
  logic [1:0] pd_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] count_r;
  logic wr_take;
  logic [31:0] status_word;

  assign wr_take = avs_write & ~wait_r;

  // One wait cycle per access keeps readdata a plain register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_r <= AOBF_CTRL_RESET;
    end else if (wr_take && avs_address == AOBF_CTRL_OFS && avs_byteenable[0]) begin
      pd_r <= {avs_writedata[AOBF_CTRL_PD_B], avs_writedata[AOBF_CTRL_PD_A]};
    end
  end

  // Channel pipeline state, indexed by channel except the shared pair_r
  logic pair_r;
  logic [AOBF_CHANS-1:0] fwd_r;
  logic [AOBF_CHANS-1:0] flag_r;
  logic [AOBF_CHANS-1:0] oe_n_r;
  logic [AOBF_CODE_W-1:0] late_r [AOBF_CHANS];
  logic [AOBF_CODE_W-1:0] early_r [AOBF_CHANS];
  logic [AOBF_CODE_W-1:0] hold_r [AOBF_CHANS];

  always_comb begin
    status_word = AOBF_ZERO_WORD;
    status_word[AOBF_ST_SINGLE] = single_mode;
    status_word[AOBF_ST_PHASE90] = phase90;
    status_word[AOBF_ST_PAIR] = pair_r;
    status_word[AOBF_ST_RANGE_A] = flag_r[0];
    status_word[AOBF_ST_RANGE_B] = flag_r[1];
    status_word[AOBF_ST_FWD_A] = fwd_r[0];
    status_word[AOBF_ST_FWD_B] = fwd_r[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= AOBF_ZERO_WORD;
    end else if (avs_read && wait_r) begin
      unique case (avs_address)
        AOBF_CTRL_OFS: begin
          rdata_r <= AOBF_ZERO_WORD;
          rdata_r[AOBF_CTRL_PD_A] <= pd_r[0];
          rdata_r[AOBF_CTRL_PD_B] <= pd_r[1];
        end
        AOBF_STATUS_OFS: begin
          rdata_r <= status_word;
        end
        AOBF_COUNT_OFS: begin
          rdata_r <= count_r;
        end
        default: begin
          rdata_r <= AOBF_ZERO_WORD;
        end
      endcase
    end
  end

  // Sampling-clock rising edges seen, free running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= AOBF_ZERO_WORD;
    end else if (strobe) begin
      count_r <= count_r + AOBF_COUNT_STEP;
    end
  end

  // Shared pair position keeps both channels in lockstep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pair_r <= 1'b0;
    end else if (single_mode) begin
      pair_r <= 1'b0;
    end else if (strobe) begin
      pair_r <= ~pair_r;
    end
  end

  // Launch strobe: every sample in single mode, the second of a pair in split mode.
  // Park strobe: the first of a pair in split mode, which only fills the holding word.
  logic launch;
  logic park;
  assign launch = strobe & (single_mode | pair_r);
  assign park = strobe & ~single_mode & ~pair_r;

  // Forwarded clock; both channels share strobe and pair, so they stay in phase unless one has been powered down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_r <= '0;
    end else begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        if (pd_r[i]) begin
          // A powered-down channel restarts its clock from low, so its phase is lost
          fwd_r[i] <= 1'b0;
        end else if (strobe && single_mode) begin
          // One toggle per sample: half the sampling rate
          fwd_r[i] <= ~fwd_r[i];
        end else if (strobe && (pair_r ^ phase90)) begin
          // One toggle per pair: a quarter of the sampling rate
          fwd_r[i] <= ~fwd_r[i];
        end
      end
    end
  end

  // Range flag travels with the word that it describes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        if (pd_r[i]) begin
          flag_r[i] <= 1'b0;
        end else if (launch) begin
          // Split mode flags the late word only; the early word carries no flag
          flag_r[i] <= out_of_range(smp[i]);
        end
      end
    end
  end

  // Primary bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        late_r[i] <= AOBF_CODE_MIN;
      end
    end else begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        if (pd_r[i]) begin
          late_r[i] <= AOBF_CODE_MIN;
        end else if (strobe && single_mode) begin
          late_r[i] <= sat_code(smp[i]);
        end else if (launch) begin
          late_r[i] <= sat_code(smp[i]);
        end
      end
    end
  end

  // Holding word for the earlier sample of a pair; kept across power-down, since it is
  // overwritten before it is ever launched again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        hold_r[i] <= AOBF_CODE_MIN;
      end
    end else begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        if (park) begin
          hold_r[i] <= sat_code(smp[i]);
        end
      end
    end
  end

  // Secondary bus; reads zero whenever it is not driven
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        early_r[i] <= AOBF_CODE_MIN;
      end
    end else begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        if (pd_r[i]) begin
          early_r[i] <= AOBF_CODE_MIN;
        end else if (strobe && single_mode) begin
          early_r[i] <= AOBF_CODE_MIN;
        end else if (launch) begin
          early_r[i] <= hold_r[i];
        end
      end
    end
  end

  // Secondary bus enable, low while driven; it turns on at the first split strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_n_r <= '1;
    end else begin
      for (int i = 0; i < AOBF_CHANS; i++) begin
        if (pd_r[i]) begin
          oe_n_r[i] <= 1'b1;
        end else if (strobe && single_mode) begin
          oe_n_r[i] <= 1'b1;
        end else if (strobe) begin
          oe_n_r[i] <= 1'b0;
        end
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign fwd_clock_chan_a = fwd_r[0];
  assign fwd_clock_chan_b = fwd_r[1];
  assign range_flag_chan_a = flag_r[0];
  assign range_flag_chan_b = flag_r[1];
  assign late_word_chan_a = late_r[0];
  assign late_word_chan_b = late_r[1];
  assign early_word_chan_a = early_r[0];
  assign early_word_chan_b = early_r[1];
  assign early_oe_n_chan_a = oe_n_r[0];
  assign early_oe_n_chan_b = oe_n_r[1];

endmodule

// file: src/aobf_pkg.sv
// Package for the converter output bus formatter: widths, register map,
// field positions, reset values and the sample carrier struct.
// Assumes a single 40 MHz system clock and an Avalon-MM slave register port.
package aobf_pkg;

  localparam int unsigned AOBF_CODE_W = 10;
  localparam int unsigned AOBF_CHANS = 2;
  localparam logic [AOBF_CODE_W-1:0] AOBF_CODE_MAX = 10'h3FF;
  localparam logic [AOBF_CODE_W-1:0] AOBF_CODE_MIN = 10'h000;

  // Avalon-MM register map, byte addresses
  localparam int unsigned AOBF_ADDR_W = 4;
  localparam logic [AOBF_ADDR_W-1:0] AOBF_CTRL_OFS = 4'h0;
  localparam logic [AOBF_ADDR_W-1:0] AOBF_STATUS_OFS = 4'h4;
  localparam logic [AOBF_ADDR_W-1:0] AOBF_COUNT_OFS = 4'h8;

  // Control register fields
  localparam int unsigned AOBF_CTRL_PD_A = 0;
  localparam int unsigned AOBF_CTRL_PD_B = 1;
  localparam logic [1:0] AOBF_CTRL_RESET = 2'h0;

  // Status register fields
  localparam int unsigned AOBF_ST_SINGLE = 0;
  localparam int unsigned AOBF_ST_PHASE90 = 1;
  localparam int unsigned AOBF_ST_PAIR = 2;
  localparam int unsigned AOBF_ST_RANGE_A = 3;
  localparam int unsigned AOBF_ST_RANGE_B = 4;
  localparam int unsigned AOBF_ST_FWD_A = 5;
  localparam int unsigned AOBF_ST_FWD_B = 6;

  localparam logic [31:0] AOBF_ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] AOBF_COUNT_STEP = 32'h0000_0001;

  // One converted sample as delivered by the converter core
  typedef struct packed {
    logic over_pos;
    logic over_neg;
    logic [AOBF_CODE_W-1:0] code;
  } aobf_sample_s;

endpackage

// file: testbench/aobf_assertions.sv
// Checker for the output bus formatter, bound onto its top ports.
// Assumes static mode straps and a sampling clock well below clk.
module aobf_checker import aobf_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_split_select,
  input wire logic edge_phase_select,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic fwd_clock_chan_a,
  input wire logic range_flag_chan_a,
  input wire logic range_flag_chan_b,
  input wire logic [AOBF_CODE_W-1:0] late_word_chan_a,
  input wire logic [AOBF_CODE_W-1:0] late_word_chan_b,
  input wire logic early_oe_n_chan_a
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_one_wait;
    s_req_waiting |=> s_one_wait;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bad wait state");
  property p_idle_wait;
    !avs_read && !avs_write |-> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("idle without wait");
  property p_flag_a;
    range_flag_chan_a |-> late_word_chan_a == AOBF_CODE_MAX || late_word_chan_a == AOBF_CODE_MIN;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("flag a on unsaturated word");
  property p_flag_b;
    range_flag_chan_b |-> late_word_chan_b == AOBF_CODE_MAX || late_word_chan_b == AOBF_CODE_MIN;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("flag b on unsaturated word");
  property p_single_fwd;
    $changed(late_word_chan_a) && early_oe_n_chan_a |-> $changed(fwd_clock_chan_a);
  endproperty
  a_single_fwd: assert property (p_single_fwd) else $error("single word without clock edge");
  property p_split0;
    $changed(late_word_chan_a) && !early_oe_n_chan_a && !edge_phase_select && !$past(edge_phase_select, 4)
      |-> $changed(fwd_clock_chan_a);
  endproperty
  a_split0: assert property (p_split0) else $error("0 degree data off clock edge");
  property p_split90;
    $changed(late_word_chan_a) && !early_oe_n_chan_a && edge_phase_select && $past(edge_phase_select, 4)
      |-> $stable(fwd_clock_chan_a);
  endproperty
  a_split90: assert property (p_split90) else $error("90 degree data on clock edge");
  property p_oe_fall;
    $fell(early_oe_n_chan_a) |-> !bus_split_select && late_word_chan_a == $past(late_word_chan_a);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("early bus driven wrongly");
endmodule
bind aobf_formatter aobf_checker u_chk (.clk(clk), .rst(rst), .bus_split_select(bus_split_select),
  .edge_phase_select(edge_phase_select), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .fwd_clock_chan_a(fwd_clock_chan_a), .range_flag_chan_a(range_flag_chan_a),
  .range_flag_chan_b(range_flag_chan_b), .late_word_chan_a(late_word_chan_a),
  .late_word_chan_b(late_word_chan_b), .early_oe_n_chan_a(early_oe_n_chan_a));

// file: testbench/aobf_capture_model.sv
// Receiver model latching channel A buses on both forwarded clock edges.
// Assumes buses launch with that clock, so clk sampling sees them settled.
module aobf_capture_model import aobf_pkg::*; (
  input wire logic clk,
  input wire logic fwd_clock,
  input wire logic [AOBF_CODE_W-1:0] late_word,
  input wire logic [AOBF_CODE_W-1:0] early_word,
  output logic [AOBF_CODE_W-1:0] cap_late,
  output logic [AOBF_CODE_W-1:0] cap_early
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fwd_seen_r = 1'h0;
  always @(posedge clk) begin
    if (fwd_clock !== fwd_seen_r) begin
      cap_late <= late_word;
      cap_early <= early_word;
    end
    fwd_seen_r <= fwd_clock;
  end
endmodule

// file: testbench/adc_output_bus_formatter_test.sv
// Self-checking bench for the output bus formatter with a capture model.
// Assumes a 40 MHz clk and a free-running 200 ns sampling clock pin.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module adc_output_bus_formatter_test import aobf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic sgl;
    logic ph;
    aobf_sample_s s;
    logic [9:0] late;
    logic [9:0] early;
    logic flag;
    logic oe_n;
    logic tog;
  } aobf_row_s;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sample_clk_pin = 1'h0;
  logic bus_split_select = 1'h1;
  logic edge_phase_select = 1'h0;
  aobf_sample_s sa = '0;
  aobf_sample_s sb = '0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, fa, fb, ra, rb, oa, ob, prev;
  logic [9:0] la, lb, ea, eb, cl, ce;
  int num_errors = 0;
  int checked = 0;
  // Same sample on both channels; first-of-pair rows expect unchanged words and flags
  aobf_row_s rows [9] = '{
    '{1'h1, 1'h0, 12'h155, 10'h155, 10'h000, 1'h0, 1'h1, 1'h1},
    '{1'h1, 1'h0, 12'h812, 10'h3FF, 10'h000, 1'h1, 1'h1, 1'h1},
    '{1'h1, 1'h0, 12'h6AA, 10'h000, 10'h000, 1'h1, 1'h1, 1'h1},
    '{1'h1, 1'h1, 12'hD00, 10'h3FF, 10'h000, 1'h1, 1'h1, 1'h1},
    '{1'h0, 1'h0, 12'h0AA, 10'h3FF, 10'h000, 1'h1, 1'h0, 1'h0},
    '{1'h0, 1'h0, 12'h0BB, 10'h0BB, 10'h0AA, 1'h0, 1'h0, 1'h1},
    '{1'h0, 1'h1, 12'h0CC, 10'h0BB, 10'h0AA, 1'h0, 1'h0, 1'h1},
    '{1'h0, 1'h1, 12'h8DD, 10'h3FF, 10'h0CC, 1'h1, 1'h0, 1'h0},
    '{1'h1, 1'h0, 12'h077, 10'h077, 10'h000, 1'h0, 1'h1, 1'h1}};
  aobf_formatter dut (.clk(clk), .rst(rst), .sample_clk_pin(sample_clk_pin), .bus_split_select(bus_split_select),
    .edge_phase_select(edge_phase_select), .sample_chan_a(sa), .sample_chan_b(sb), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fwd_clock_chan_a(fa), .fwd_clock_chan_b(fb),
    .range_flag_chan_a(ra), .range_flag_chan_b(rb), .late_word_chan_a(la), .late_word_chan_b(lb),
    .early_word_chan_a(ea), .early_word_chan_b(eb), .early_oe_n_chan_a(oa), .early_oe_n_chan_b(ob));
  aobf_capture_model rx (.clk(clk), .fwd_clock(fa), .late_word(la), .early_word(ea), .cap_late(cl), .cap_early(ce));
  initial forever #12.5 clk = ~clk;
  initial #13 forever #100 sample_clk_pin = ~sample_clk_pin;
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  // Drives well after a sampling edge, so the next edge takes it cleanly
  task automatic push(input aobf_row_s r);
    @(posedge clk);
    bus_split_select <= r.sgl;
    edge_phase_select <= r.ph;
    sa <= r.s;
    sb <= r.s;
    prev = fa;
    @(posedge sample_clk_pin);
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("Errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    `CHK(avs_waitrequest, 1'h1)
    `CHK(oa, 1'h1)
    rst <= 1'h0;
    foreach (rows[i]) begin
      push(rows[i]);
      `CHK(la, rows[i].late)
      `CHK(lb, rows[i].late)
      `CHK(ra, rows[i].flag)
      `CHK(ea, rows[i].early)
      `CHK(eb, rows[i].early)
      `CHK(rb, rows[i].flag)
      `CHK(oa, rows[i].oe_n)
      `CHK(fa, prev ^ rows[i].tog)
      `CHK(fb, fa)
      if (rows[i].tog) `CHK(cl, rows[i].late)
    end
    bus(1'h0, 4'hC, 32'h0);
    `CHK(rd, AOBF_ZERO_WORD)
    bus(1'h1, AOBF_CTRL_OFS, 32'h2);
    bus(1'h0, AOBF_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h2)
    push(rows[1]);
    `CHK(la, 10'h3FF)
    `CHK(lb, 10'h000)
    `CHK(rb, 1'h0)
    `CHK(ob, 1'h1)
    bus(1'h1, AOBF_STATUS_OFS, 32'hFF);
    bus(1'h0, AOBF_STATUS_OFS, 32'h0);
    `CHK(rd[AOBF_ST_SINGLE], 1'h1)
    `CHK(rd[AOBF_ST_RANGE_A], 1'h1)
    `CHK(rd[AOBF_ST_RANGE_B], 1'h0)
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    #1;
    `CHK(fa, 1'h0)
    `CHK(la, 10'h000)
    `CHK(avs_waitrequest, 1'h1)
    @(posedge clk);
    rst <= 1'h0;
    bus(1'h0, AOBF_CTRL_OFS, 32'h0);
    `CHK(rd, AOBF_ZERO_WORD)
    results();
  end
endmodule
